// file: ctc_control_timer.sv
// control timer counter core: counter, commands, event actions, two compare channels
// assumes an APB master on sys_clk and event inputs that are asynchronous to sys_clk
// Functional notes
// [R1] counting up at TOP, next tick loads zero and sets the wrap flag
// [R2] counting down at ZERO, next tick reloads TOP and sets the wrap flag
// [R3] single-pass bit set: a wrap halts counting
// [R4] software count write wins over count, clear and reload; direction changes live
// [R5] start loads ZERO or TOP unless written or halted at nonzero
// [R6] stop command drops the count, forces safe outputs, sets halted status
// [R7] pause event freezes count and waveforms until a start event or a retrigger
// [R8] retrigger while counting clears or reloads, sets retrigger flag, optional event
// [R9] retrigger while halted restarts from ZERO or TOP by direction
// [R10] retrigger action: enabling waits; each event starts or restarts
// [R11] start action: enabling waits; start or software retrigger starts; ignored while running
// [R12] count action: each input zero event steps by direction
// [R13] direction action: input one level overrides the direction bit
// [R14] increment action: input zero event always counts up
// [R15] decrement action: input one event always counts down
// [R16] fault action: event halts counter and forces safe outputs
// [R17] actions off: enabling starts counting at once
// [R18] count equal compare sets match flag at tick, with irq and event if enabled
// [R19] compare values load from shadow at update or forced update command
// [R20] seven waveform modes; TOP from channel zero compare or period value
// [R21] dual-slope updates at ZERO, both-ends also at TOP with circular; others at wrap or on a retrigger while counting
// [R22] wrap event at TOP up, ZERO down; dual-slope at ZERO, top and both also TOP
// [R23] counting events bypasses the prescaler
`timescale 1ns/100ps
`include "ctc_defs.svh"

module ctc_control_timer (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`CTC_AW-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 input_event_zero,
  input  wire logic                 input_event_one,
  output logic      [`CTC_NCH-1:0]  wave_out,
  output logic                      wrap_event,
  output logic                      retrigger_event,
  output logic      [`CTC_NCH-1:0]  channel_match_event,
  output logic      [`CTC_NCH-1:0]  channel_match_irq
);
  import ctc_pkg::*;

  localparam int W = `CTC_W;

  function automatic logic addr_ok(input logic [`CTC_AW-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `CTC_OFF_CCBUF1);
  endfunction

  function automatic logic is_dual(input ctc_wave_type m);
    is_dual = (m != WV_TOGGLE_ON_PERIOD) && (m != WV_TOGGLE_ON_CHANNEL_ZERO) &&
              (m != WV_SINGLE_SLOPE_PWM);
  endfunction

  // prescaler divide-by minus one: 1,2,4,8,16,64,256,1024
  function automatic logic [9:0] presc_limit(input logic [2:0] s);
    unique case (s)
      3'h0: presc_limit = 10'h000;
      3'h1: presc_limit = 10'h001;
      3'h2: presc_limit = 10'h003;
      3'h3: presc_limit = 10'h007;
      3'h4: presc_limit = 10'h00f;
      3'h5: presc_limit = 10'h03f;
      3'h6: presc_limit = 10'h0ff;
      3'h7: presc_limit = 10'h3ff;
    endcase
  endfunction

  logic                en_r;
  logic [2:0]          presc_sel_r;
  logic                oneshot_r;
  logic                lupd_r;
  logic                dir_r;
  logic [2:0]          act0_r;
  logic [2:0]          act1_r;
  logic                trgeo_r;
  logic [`CTC_NCH-1:0] mceo_r;
  logic [`CTC_NCH-1:0] nre_r;
  logic [`CTC_NCH-1:0] nrv_r;
  logic [`CTC_NCH-1:0] inven_r;
  ctc_wave_type        wave_r;
  logic                circ_r;
  logic [`CTC_NCH-1:0] inten_r;
  logic                wrap_flag_r;
  logic                retrigger_flag_r;
  logic [`CTC_NCH-1:0] match_flag_r;
  logic                halted_r;
  logic [`CTC_NCH-1:0] bufv_r;
  logic [W-1:0]        count_r;
  logic [W-1:0]        per_r;
  logic [W-1:0]        cc_r [`CTC_NCH];
  logic [W-1:0]        ccbuf_r [`CTC_NCH];
  logic                cnt_written_r;
  logic                safe_r;
  logic [9:0]          presc_cnt_r;
  logic [1:0]          ev_meta_r;
  logic [1:0]          ev_sync_r;
  logic [1:0]          ev_prev_r;
  logic [`CTC_NCH-1:0] wave_r_q;
  ctc_state_type       state_r;
  ctc_state_type       state_nxt;

  // bus decode: a transfer completes on the edge that sees pready high
  logic          acc;
  logic          wr;
  logic [2:0]    cmd;
  logic [1:0]    ev_pulse;
  logic          retrig;
  logic          start_ev;
  logic          pause_ev;
  logic          fault_ev;
  logic          stop_cmd;
  logic          cnt_wr;
  logic          by_events;
  logic          tick_inc;
  logic          tick_dec;
  logic          tick;
  logic          step_up;
  logic [W-1:0]  top;
  logic [W-1:0]  start_val;
  logic          dual;
  logic          run;
  logic          adv;
  logic          wrap;
  logic          ovf_hit;
  logic          upd_cond;
  logic          starting;
  logic          quiet;
  logic [`CTC_NCH-1:0] mhit;

  assign acc       = psel && penable && pready;
  assign wr        = acc && pwrite && addr_ok(paddr);
  assign cmd       = (wr && paddr == `CTC_OFF_CTRLB) ? pwdata[`CTC_CMD_LSB +: 3] : `CTC_CMD_NONE;
  assign cnt_wr    = wr && (paddr == `CTC_OFF_COUNT);
  assign ev_pulse  = ev_sync_r & ~ev_prev_r;
  assign stop_cmd  = (cmd == `CTC_CMD_STOP);
  assign retrig    = (cmd == `CTC_CMD_RETRIG) || (ev_pulse[0] && act0_r == `CTC_ACT_RETRIG) ||
                     (ev_pulse[1] && act1_r == `CTC_ACT_RETRIG);
  assign start_ev  = ev_pulse[0] && (act0_r == `CTC_ACT_START);
  assign pause_ev  = ev_pulse[1] && (act1_r == `CTC_ACT_PAUSE);
  assign fault_ev  = (ev_pulse[0] && act0_r == `CTC_ACT_FAULT) ||
                     (ev_pulse[1] && act1_r == `CTC_ACT_FAULT);
  assign quiet     = en_r && !cnt_wr && !retrig && !stop_cmd && !fault_ev && !pause_ev;

  // tick source: events replace the prescaler when counting events
  assign by_events = (act0_r == `CTC_ACT_COUNT) || (act0_r == `CTC_ACT_INC) ||
                     (act1_r == `CTC_ACT_DEC); // R23
  assign tick_inc  = ev_pulse[0] && (act0_r == `CTC_ACT_COUNT || act0_r == `CTC_ACT_INC); // R12
  assign tick_dec  = ev_pulse[1] && (act1_r == `CTC_ACT_DEC); // R15
  // simultaneous forced up and down steps cancel out
  assign tick      = by_events ? (tick_inc ^ tick_dec) :
                     (presc_cnt_r == presc_limit(presc_sel_r)); // R23
  assign step_up   = (tick_inc && act0_r == `CTC_ACT_INC) ? 1'b1 : // R14
                     tick_dec ? 1'b0 : !dir_r; // R12 R15
  assign top       = (wave_r == WV_TOGGLE_ON_CHANNEL_ZERO) ? cc_r[0] : per_r; // R20
  assign start_val = dir_r ? top : {W{1'b0}};
  assign dual      = is_dual(wave_r);
  assign run       = (state_r == ST_RUN);
  assign adv       = run && tick;
  assign wrap      = adv && (step_up ? (count_r == top) : (count_r == {W{1'b0}}));
  assign ovf_hit   = wrap && (!dual || !step_up || wave_r == WV_DUAL_SLOPE_TOP_IRQ ||
                     wave_r == WV_DUAL_SLOPE_BOTH_IRQ); // R22
  assign upd_cond  = dual ? (wrap && (!step_up || (wave_r == WV_DUAL_SLOPE_BOTH_IRQ && circ_r)))
                          : (wrap || (run && retrig)); // R21
  assign starting  = (state_r != ST_RUN) && (state_nxt == ST_RUN);

  // apb slave: one wait state, read data and error ready with pready
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok(paddr);
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          `CTC_OFF_CTRLA:   prdata <= {28'h0, presc_sel_r, en_r};
          `CTC_OFF_CTRLB:   prdata <= {29'h0, lupd_r, oneshot_r, dir_r};
          `CTC_OFF_EVCTRL:  prdata <= {20'h0, mceo_r, 1'b0, trgeo_r, 1'b0, act1_r, 1'b0, act0_r};
          `CTC_OFF_DRVCTRL: prdata <= {14'h0, inven_r, 6'h0, nrv_r, 6'h0, nre_r};
          `CTC_OFF_WAVE:    prdata <= {27'h0, circ_r, 1'b0, wave_r};
          `CTC_OFF_INTEN:   prdata <= {30'h0, inten_r};
          `CTC_OFF_FLAGS:   prdata <= {22'h0, bufv_r, 3'h0, halted_r, match_flag_r,
                                       retrigger_flag_r, wrap_flag_r};
          `CTC_OFF_COUNT:   prdata <= {16'h0, count_r};
          `CTC_OFF_PER:     prdata <= {16'h0, per_r};
          `CTC_OFF_CC0:     prdata <= {16'h0, cc_r[0]};
          `CTC_OFF_CC1:     prdata <= {16'h0, cc_r[1]};
          `CTC_OFF_CCBUF0:  prdata <= {16'h0, ccbuf_r[0]};
          `CTC_OFF_CCBUF1:  prdata <= {16'h0, ccbuf_r[1]};
          default:          prdata <= 32'h0;
        endcase
      end
    end
  end

  // configuration; event and drive controls only change while disabled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_r <= 1'b0; presc_sel_r <= 3'h0; oneshot_r <= 1'b0; lupd_r <= 1'b0;
      act0_r <= `CTC_ACT_OFF; act1_r <= `CTC_ACT_OFF; trgeo_r <= 1'b0; mceo_r <= '0;
      nre_r <= '0; nrv_r <= '0; inven_r <= '0;
      wave_r <= WV_TOGGLE_ON_PERIOD; circ_r <= 1'b0; inten_r <= '0; per_r <= `CTC_PER_RST;
    end else if (wr) begin
      unique case (paddr)
        `CTC_OFF_CTRLA: begin
          en_r        <= pwdata[`CTC_EN_BIT];
          presc_sel_r <= en_r ? presc_sel_r : pwdata[`CTC_PRESC_LSB +: 3];
        end
        `CTC_OFF_CTRLB: begin
          oneshot_r <= pwdata[`CTC_ONESHOT_BIT];
          lupd_r    <= pwdata[`CTC_LUPD_BIT];
        end
        `CTC_OFF_EVCTRL: if (!en_r) begin
          act0_r  <= pwdata[`CTC_ACT0_LSB +: 3];
          act1_r  <= pwdata[`CTC_ACT1_LSB +: 3];
          trgeo_r <= pwdata[`CTC_TRGEO_BIT];
          mceo_r  <= pwdata[`CTC_MCEO_LSB +: `CTC_NCH];
        end
        `CTC_OFF_DRVCTRL: if (!en_r) begin
          nre_r   <= pwdata[`CTC_NRE_LSB +: `CTC_NCH];
          nrv_r   <= pwdata[`CTC_NRV_LSB +: `CTC_NCH];
          inven_r <= pwdata[`CTC_INVEN_LSB +: `CTC_NCH];
        end
        `CTC_OFF_WAVE: begin
          // code 7 is not a mode and is ignored
          if (pwdata[2:0] != 3'h7) wave_r <= ctc_wave_type'(pwdata[2:0]); // R20
          circ_r <= pwdata[`CTC_CIRC_BIT];
        end
        `CTC_OFF_INTEN: inten_r <= pwdata[`CTC_NCH-1:0];
        `CTC_OFF_PER:   per_r   <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end

  // event inputs: two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ev_meta_r <= 2'h0; ev_sync_r <= 2'h0; ev_prev_r <= 2'h0;
    end else begin
      ev_meta_r <= {input_event_one, input_event_zero};
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  // prescaler runs only while counting clock ticks
  always_ff @(posedge sys_clk) begin
    if (srst || !run || by_events || tick) presc_cnt_r <= 10'h000;
    else presc_cnt_r <= presc_cnt_r + 10'h001;
  end

  // run state
  always_comb begin
    state_nxt = state_r;
    if (!en_r) state_nxt = ST_IDLE;
    else if (fault_ev) state_nxt = ST_FAULT; // R16
    else begin
      unique case (state_r)
        ST_IDLE: state_nxt = (act0_r == `CTC_ACT_RETRIG || act1_r == `CTC_ACT_RETRIG ||
                              act0_r == `CTC_ACT_START) ? ST_WAIT : ST_RUN; // R10 R11 R17
        ST_WAIT, ST_HALT:
          if (retrig || start_ev) state_nxt = ST_RUN; // R9 R10 R11
        ST_PAUSE:
          if (retrig || start_ev) state_nxt = ST_RUN; // R7
        ST_RUN:
          if (stop_cmd) state_nxt = ST_HALT; // R6
          else if (pause_ev) state_nxt = ST_PAUSE; // R7
          else if (wrap && oneshot_r && !retrig) state_nxt = ST_HALT; // R3
        ST_FAULT: state_nxt = ST_FAULT;
        default:  state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // counter value; the software write takes priority over every other change
  always_ff @(posedge sys_clk) begin
    if (srst) count_r <= {W{1'b0}};
    else if (cnt_wr) count_r <= pwdata[W-1:0]; // R4
    else if (starting && retrig) count_r <= start_val; // R9
    else if (starting) count_r <= (!cnt_written_r && count_r == {W{1'b0}}) ? start_val
                                                                            : count_r; // R5
    else if (run && stop_cmd) count_r <= {W{1'b0}}; // R6
    else if (run && retrig) count_r <= start_val; // R8
    else if (adv && !fault_ev && !pause_ev) begin
      if (wrap && !dual) count_r <= step_up ? {W{1'b0}} : top; // R1 R2
      else if (wrap) count_r <= step_up ? top - 16'h0001 : 16'h0001;
      else count_r <= step_up ? count_r + 16'h0001 : count_r - 16'h0001; // R12 R14 R15
    end
  end

  // software-written marker consumed by the next start
  always_ff @(posedge sys_clk) begin
    if (srst || starting) cnt_written_r <= 1'b0;
    else if (cnt_wr) cnt_written_r <= 1'b1;
  end

  // direction: software, level of input one, or slope reversal in dual-slope modes
  always_ff @(posedge sys_clk) begin
    if (srst) dir_r <= 1'b0;
    else if (act1_r == `CTC_ACT_DIR && en_r) dir_r <= ev_sync_r[1]; // R13
    else if (wr && paddr == `CTC_OFF_CTRLB) dir_r <= pwdata[`CTC_DIR_BIT]; // R4
    else if (adv && wrap && dual && quiet) dir_r <= step_up;
  end

  // sticky flags: write one to clear, a coincident set wins; halted status clears at start or disable instead
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrap_flag_r <= 1'b0; retrigger_flag_r <= 1'b0; match_flag_r <= '0; halted_r <= 1'b0;
    end else begin
      wrap_flag_r <= (wrap_flag_r && !(wr && paddr == `CTC_OFF_FLAGS && pwdata[`CTC_FL_WRAP])) ||
                     (ovf_hit && !cnt_wr); // R1 R2 R22
      retrigger_flag_r <= (retrigger_flag_r &&
                           !(wr && paddr == `CTC_OFF_FLAGS && pwdata[`CTC_FL_TRG])) ||
                          (run && retrig); // R8
      match_flag_r <= (match_flag_r &
                       ~({`CTC_NCH{wr && paddr == `CTC_OFF_FLAGS}} &
                         pwdata[`CTC_FL_MC_LSB +: `CTC_NCH])) | mhit; // R18
      if (starting || !en_r) halted_r <= 1'b0;
      else if (run && stop_cmd) halted_r <= 1'b1; // R6
    end
  end

  // safe state held from stop or fault until the counter starts again or is disabled
  always_ff @(posedge sys_clk) begin
    if (srst || starting || !en_r) safe_r <= 1'b0;
    else if (fault_ev || (run && stop_cmd)) safe_r <= 1'b1; // R6 R16
  end

  // event and interrupt request outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrap_event <= 1'b0; retrigger_event <= 1'b0;
      channel_match_event <= '0; channel_match_irq <= '0;
    end else begin
      wrap_event          <= ovf_hit; // R22
      retrigger_event     <= run && retrig && trgeo_r; // R8
      channel_match_event <= mhit & mceo_r; // R18
      channel_match_irq   <= match_flag_r & inten_r; // R18
    end
  end

  // per channel: match, shadow copy, waveform
  for (genvar i = 0; i < `CTC_NCH; i++) begin : g_ch
    logic ld;
    assign mhit[i] = adv && (count_r == cc_r[i]);
    // copies only written buffer values, at the update condition while lupd_r is clear, or at once on the update command, even mid-period
    assign ld = bufv_r[i] && ((upd_cond && !lupd_r) || cmd == `CTC_CMD_UPDATE); // R19

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        cc_r[i] <= {W{1'b0}}; ccbuf_r[i] <= {W{1'b0}}; bufv_r[i] <= 1'b0;
      end else begin
        if (wr && paddr == `CTC_OFF_CC0 + 8'(4 * i)) cc_r[i] <= pwdata[W-1:0];
        else if (ld) cc_r[i] <= ccbuf_r[i]; // R19
        if (wr && paddr == `CTC_OFF_CCBUF0 + 8'(4 * i)) begin
          ccbuf_r[i] <= pwdata[W-1:0];
          bufv_r[i]  <= 1'b1;
        end else if (ld) bufv_r[i] <= 1'b0;
      end
    end

    // waveform state freezes outside the running state, which covers pause, and clears to zero while disabled
    always_ff @(posedge sys_clk) begin
      if (srst || !en_r) wave_r_q[i] <= 1'b0;
      else if (run) begin
        unique case (wave_r)
          WV_TOGGLE_ON_PERIOD: if (mhit[i]) wave_r_q[i] <= !wave_r_q[i];
          WV_TOGGLE_ON_CHANNEL_ZERO:
            if ((i == 0) ? upd_cond : mhit[i]) wave_r_q[i] <= !wave_r_q[i];
          WV_SINGLE_SLOPE_PWM:
            if (wrap) wave_r_q[i] <= step_up;
            else if (mhit[i]) wave_r_q[i] <= !step_up;
          default: if (mhit[i]) wave_r_q[i] <= step_up;
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) wave_out[i] <= 1'b0;
      else if (safe_r && nre_r[i]) wave_out[i] <= nrv_r[i]; // R6 R16
      else wave_out[i] <= wave_r_q[i] ^ inven_r[i];
    end
  end

  chk_up_wrap_zero: assert property (@(posedge sys_clk) disable iff (srst) // R1
    (wrap && step_up && !dual && quiet) |=> (count_r == 16'h0000) && wrap_flag_r)
    else $error("up wrap did not load zero and set wrap flag");
  chk_down_reload_top: assert property (@(posedge sys_clk) disable iff (srst) // R2
    (wrap && !step_up && !dual && quiet) |=> (count_r == $past(top)) && wrap_flag_r)
    else $error("down wrap did not reload top");
  chk_single_pass_halt: assert property (@(posedge sys_clk) disable iff (srst) // R3
    (wrap && oneshot_r && quiet) |=> (state_r == ST_HALT) ##1 (count_r == $past(count_r)))
    else $error("single pass did not halt");
  chk_count_write_wins: assert property (@(posedge sys_clk) disable iff (srst) // R4
    cnt_wr |=> count_r == $past(pwdata[15:0]))
    else $error("count write lost");
  chk_stop_command: assert property (@(posedge sys_clk) disable iff (srst) // R6
    (run && stop_cmd && en_r && !fault_ev) |=> (state_r == ST_HALT) && halted_r &&
    (count_r == 16'h0000 || $past(cnt_wr)) ##2 (wave_out == ((wave_out & ~nre_r) | (nrv_r & nre_r))))
    else $error("stop did not halt into safe state");
  chk_retrig_running: assert property (@(posedge sys_clk) disable iff (srst) // R8
    (run && retrig && !cnt_wr && !stop_cmd && !fault_ev && en_r) |=>
    (count_r == $past(start_val)) && retrigger_flag_r && (retrigger_event == $past(trgeo_r)))
    else $error("retrigger while running mishandled");
  chk_start_ignored: assert property (@(posedge sys_clk) disable iff (srst) // R11
    (run && start_ev && quiet && !wrap) |=> state_r == ST_RUN)
    else $error("start event disturbed a running counter");
  chk_inc_forced: assert property (@(posedge sys_clk) disable iff (srst) // R14
    (adv && tick_inc && act0_r == `CTC_ACT_INC && quiet && !wrap) |=>
    count_r == $past(count_r) + 16'h0001)
    else $error("increment action did not count up");
  chk_fault_halts: assert property (@(posedge sys_clk) disable iff (srst) // R16
    (fault_ev && en_r) |=> (state_r == ST_FAULT) && safe_r)
    else $error("fault event did not halt");
  chk_off_starts: assert property (@(posedge sys_clk) disable iff (srst) // R17
    (state_r == ST_IDLE && en_r && act0_r == `CTC_ACT_OFF && act1_r == `CTC_ACT_OFF) |=>
    state_r == ST_RUN)
    else $error("enable with actions off did not start");
  chk_match_flag: assert property (@(posedge sys_clk) disable iff (srst) // R18
    mhit[0] |=> match_flag_r[0] && (channel_match_event[0] == $past(mceo_r[0])))
    else $error("match flag not set");
endmodule

// file: ctc_defs.svh
// constants for the control timer counter core: offsets, fields, reset values, codes
// assumes a 32-bit APB slave port with byte addresses in the low 8 bits
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH

`define CTC_W             16
`define CTC_AW            8
`define CTC_NCH           2
// register byte offsets
`define CTC_OFF_CTRLA     8'h00
`define CTC_OFF_CTRLB     8'h04
`define CTC_OFF_EVCTRL    8'h08
`define CTC_OFF_DRVCTRL   8'h0c
`define CTC_OFF_WAVE      8'h10
`define CTC_OFF_INTEN     8'h14
`define CTC_OFF_FLAGS     8'h18
`define CTC_OFF_COUNT     8'h1c
`define CTC_OFF_PER       8'h20
`define CTC_OFF_CC0       8'h24
`define CTC_OFF_CC1       8'h28
`define CTC_OFF_CCBUF0    8'h2c
`define CTC_OFF_CCBUF1    8'h30
// field positions
`define CTC_EN_BIT        0
`define CTC_PRESC_LSB     1
`define CTC_DIR_BIT       0
`define CTC_ONESHOT_BIT   1
`define CTC_LUPD_BIT      2
`define CTC_CMD_LSB       4
`define CTC_ACT0_LSB      0
`define CTC_ACT1_LSB      4
`define CTC_TRGEO_BIT     8
`define CTC_MCEO_LSB      10
`define CTC_NRE_LSB       0
`define CTC_NRV_LSB       8
`define CTC_INVEN_LSB     16
`define CTC_CIRC_BIT      4
`define CTC_FL_WRAP       0
`define CTC_FL_TRG        1
`define CTC_FL_MC_LSB     2
`define CTC_FL_HALT       4
`define CTC_FL_BUFV_LSB   8
// reset values
`define CTC_PER_RST       16'hffff
// commands and event actions
`define CTC_CMD_NONE      3'h0
`define CTC_CMD_RETRIG    3'h1
`define CTC_CMD_STOP      3'h2
`define CTC_CMD_UPDATE    3'h3
`define CTC_ACT_OFF       3'h0
`define CTC_ACT_RETRIG    3'h1
`define CTC_ACT_DIR       3'h2
`define CTC_ACT_START     3'h3
`define CTC_ACT_PAUSE     3'h3
`define CTC_ACT_INC       3'h4
`define CTC_ACT_DEC       3'h4
`define CTC_ACT_COUNT     3'h5
`define CTC_ACT_FAULT     3'h7

`endif

// file: ctc_pkg.sv
// types for the control timer counter core
// assumes ctc_defs.svh supplies the numeric constants
package ctc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_WAIT  = 6'h02,
    ST_RUN   = 6'h04,
    ST_HALT  = 6'h08,
    ST_PAUSE = 6'h10,
    ST_FAULT = 6'h20
  } ctc_state_type;

  typedef enum logic [2:0] {
    WV_TOGGLE_ON_PERIOD       = 3'h0,
    WV_TOGGLE_ON_CHANNEL_ZERO = 3'h1,
    WV_SINGLE_SLOPE_PWM       = 3'h2,
    WV_DUAL_SLOPE_TOP_IRQ     = 3'h3,
    WV_DUAL_SLOPE_BOTTOM_IRQ  = 3'h4,
    WV_DUAL_SLOPE_BOTH_IRQ    = 3'h5,
    WV_DUAL_SLOPE_SPLIT_EDGES = 3'h6
  } ctc_wave_type;
endpackage

// file: control_timer_counter_core_tb.sv
// testbench for ctc_control_timer: apb tasks, event pulses, integer expectations
// assumes one apb wait state and events seen a few cycles after the pin rises
`timescale 1ns/100ps
`include "ctc_defs.svh"
module control_timer_counter_core_tb;
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic        wrap_event, retrigger_event;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ev, wave_out, mev, mirq;
  int          failures, cmp_count, cycles, wraps, seed, n0, n1;
  ctc_control_timer u_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_event_zero(ev[0]), .input_event_one(ev[1]),
    .wave_out(wave_out), .wrap_event(wrap_event), .retrigger_event(retrigger_event),
    .channel_match_event(mev), .channel_match_irq(mirq));
  // 125 mhz clock
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer; starts on a fresh edge so psel never toggles twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1;
    repeat (2) @(posedge sys_clk);
    ev[i] <= 0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // wrap pulse count and a hang guard well beyond the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (wrap_event === 1'b1) wraps++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    seed = 30121;
    {srst, psel, penable, pwrite, paddr, pwdata, ev} = {1'b1, 45'h0};
    repeat (6) @(posedge sys_clk);
    srst <= 0;
    // single pass up to TOP=3, then halt at zero
    apb(1, `CTC_OFF_PER, 32'h3);
    apb(1, `CTC_OFF_CTRLB, 32'h2);
    apb(1, `CTC_OFF_CTRLA, 32'h1);
    repeat (20) @(posedge sys_clk);
    apb(0, `CTC_OFF_COUNT, 0);
    chk(rd, 32'h0);
    chk(32'(wraps), 32'h1);
    apb(0, `CTC_OFF_FLAGS, 0);
    chk({31'h0, rd[0]}, 32'h1);
    // counting down starts at TOP and the underflow reloads TOP
    apb(1, `CTC_OFF_FLAGS, 32'h1f);
    apb(1, `CTC_OFF_CTRLA, 32'h0);
    apb(1, `CTC_OFF_CTRLB, 32'h3);
    apb(1, `CTC_OFF_CTRLA, 32'h1);
    repeat (20) @(posedge sys_clk);
    apb(0, `CTC_OFF_COUNT, 0);
    chk(rd, 32'h3);
    chk(32'(wraps), 32'h2);
    // stop while running drops the count and drives the safe levels
    apb(1, `CTC_OFF_CTRLA, 32'h0);
    apb(1, `CTC_OFF_DRVCTRL, 32'h0203);
    apb(1, `CTC_OFF_PER, 32'hffff);
    apb(1, `CTC_OFF_CTRLB, 32'h0);
    apb(1, `CTC_OFF_CTRLA, 32'h1);
    repeat (10) @(posedge sys_clk);
    apb(1, `CTC_OFF_CTRLB, 32'h20);
    apb(0, `CTC_OFF_COUNT, 0);
    chk(rd, 32'h0);
    chk({30'h0, wave_out}, 32'h2);
    apb(0, `CTC_OFF_FLAGS, 0);
    chk({31'h0, rd[4]}, 32'h1);
    // a written count sticks until a retrigger discards it
    n0 = 32'h100 + ($random(seed) & 32'hfff);
    apb(1, `CTC_OFF_COUNT, 32'(n0));
    apb(0, `CTC_OFF_COUNT, 0);
    chk(rd, 32'(n0));
    apb(1, `CTC_OFF_CTRLB, 32'h10);
    apb(0, `CTC_OFF_COUNT, 0);
    chk({31'h0, rd < 32'h20}, 32'h1);
    // inc and dec events ignore the down direction; no prescaler ticks
    apb(1, `CTC_OFF_CTRLA, 32'h0);
    apb(1, `CTC_OFF_EVCTRL, 32'h44);
    apb(1, `CTC_OFF_CTRLB, 32'h1);
    apb(1, `CTC_OFF_COUNT, 32'h100);
    apb(1, `CTC_OFF_CTRLA, 32'h1);
    n0 = 1 + ($unsigned($random(seed)) % 6);
    n1 = $unsigned($random(seed)) % 3;
    repeat (n0) pulse(0);
    repeat (n1) pulse(1);
    repeat (6) @(posedge sys_clk);
    apb(0, `CTC_OFF_COUNT, 0);
    chk(rd, 32'(32'h100 + n0 - n1));
    // unmapped offset answers with an error and reads zero
    apb(0, 8'h40, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
